// ===== core/drc_map.svh
// register offsets, field positions, reset values and figures of the loop control slice
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define DRC_IDX_RANK      8'h27
`define DRC_IDX_LOCK      8'h28
`define DRC_IDX_CAPTURE   8'h29
`define DRC_IDX_CTL_A     8'h2A
`define DRC_IDX_CTL_B     8'h2B
`define DRC_IDX_EVENTS    8'h30
`define DRC_IDX_EV_MASK   8'h31

// ---------------------------------------------------------------
// reset values and writable bits
// ---------------------------------------------------------------
`define DRC_RST_RANK      8'h76
`define DRC_RST_CAPTURE   8'h03
`define DRC_RST_CTL_A     8'h00
`define DRC_RST_CTL_B     8'h04
`define DRC_WMASK_CAPTURE 8'h03
`define DRC_WMASK_CTL_A   8'h91
`define DRC_WMASK_CTL_B   8'h03

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DRC_RANK_HI       7
`define DRC_RANK_LO       4
`define DRC_LOCK_HOLD     0
`define DRC_LOCK_LOCKED   1
`define DRC_LOCK_FAIL     2
`define DRC_CTLA_HITLESS  0
`define DRC_CTLA_SLOPE    4
`define DRC_CTLA_ENABLE   7
`define DRC_CTLB_REVERT   0
`define DRC_CTLB_OFFSET   1

// ---------------------------------------------------------------
// capture ranges in ppm and slope bound in ms/s
// ---------------------------------------------------------------
`define DRC_PPM_CODE0     8'h0C
`define DRC_PPM_CODE1     8'h34
`define DRC_PPM_CODE2     8'h82
`define DRC_PPM_CODE3     8'h53
`define DRC_SLOPE_MS_S    8'h3D

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define DRC_RESP_OKAY     2'h0
`define DRC_RESP_SLVERR   2'h2

`endif

// ===== core/drc_pkg.sv
// types shared by the loop control slice
package drc_pkg;

	// selection state, gray along free -> locked -> holdover
	typedef enum logic [1:0] {
		DRC_FREE = 2'h0,
		DRC_LOCK = 2'h1,
		DRC_HOLD = 2'h3
	} drc_sel_state_t;

	// loop operating mode as coded by the mode register
	typedef enum logic [1:0] {
		DRC_MAN_NORMAL = 2'h0,
		DRC_MAN_HOLD   = 2'h1,
		DRC_MAN_FREE   = 2'h2,
		DRC_AUTO       = 2'h3
	} drc_mode_t;

endpackage

// ===== core/drc_sel.sv
// reference selector for the first loop: rank search, switchover, holdover
`timescale 1ns/1ps
`default_nettype none

module drc_sel import drc_pkg::*; (
	input  wire logic        aclk,        // system clock
	input  wire logic        aresetn,     // synchronous reset, active low
	input  wire logic [1:0]  mode,        // operating mode code
	input  wire logic [31:0] ranks_flat,  // rank code per input, 4 bits each
	input  wire logic [7:0]  qualified,   // input passes its monitors
	input  wire logic        revertive,   // return to better input
	output logic      [2:0]  cur_ref,     // selected input
	output drc_sel_state_t   state        // free, locked or holdover
);

	logic [3:0]     rank_arr [8];
	logic [2:0]     best_idx;
	logic [3:0]     best_rank;
	logic           any_ok;
	logic           cur_ok;
	logic [2:0]     next_cur;
	drc_sel_state_t next_state;

	// ---------------------------------------------------------------
	// rank search
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_rank
			assign rank_arr[g] = ranks_flat[g*4 +: 4];
		end
	endgenerate

	// lowest code wins; a tie goes to the lower input number
	always_comb begin
		best_idx = 3'h0;
		best_rank = 4'hF;
		any_ok = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (qualified[i] && (!any_ok || rank_arr[i] < best_rank)) begin
				any_ok = 1'b1;
				best_rank = rank_arr[i];
				best_idx = 3'(i);
			end
		end
	end

	assign cur_ok = qualified[cur_ref];

	// ---------------------------------------------------------------
	// selection state
	// ---------------------------------------------------------------
	always_comb begin
		next_cur = cur_ref;
		next_state = state;
		case (drc_mode_t'(mode))
		DRC_AUTO: begin
			// ranks only count in automatic mode
			if (state == DRC_LOCK) begin
				if (!cur_ok && any_ok) begin
					next_cur = best_idx;
				end else if (!cur_ok) begin
					next_state = DRC_HOLD;
				end else if (revertive && any_ok
				             && best_rank < rank_arr[cur_ref]) begin
					next_cur = best_idx;
				end
			end else if (any_ok) begin
				next_state = DRC_LOCK;
				next_cur = best_idx;
			end
		end
		DRC_MAN_HOLD: next_state = DRC_HOLD;
		DRC_MAN_FREE: next_state = DRC_FREE;
		default: begin
			// manual normal keeps its input; loss means holdover
			if (state == DRC_LOCK && !cur_ok) begin
				next_state = DRC_HOLD;
			end else if (state != DRC_LOCK && cur_ok) begin
				next_state = DRC_LOCK;
			end
		end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_ref <= 3'h0;
			state <= DRC_FREE;
		end else begin
			cur_ref <= next_cur;
			state <= next_state;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_auto_hold;
		@(posedge aclk) disable iff (!aresetn)
		mode == DRC_AUTO && state == DRC_LOCK && !any_ok
		|=> state == DRC_HOLD;
	endproperty
	a_auto_hold: assert property (p_auto_hold)
		else $error("no qualified input but holdover not entered");

	property p_auto_switch;
		@(posedge aclk) disable iff (!aresetn)
		mode == DRC_AUTO && state == DRC_LOCK && !cur_ok && any_ok
		|=> cur_ref == $past(best_idx) && state == DRC_LOCK;
	endproperty
	a_auto_switch: assert property (p_auto_switch)
		else $error("failed input not replaced by next ranked input");

	property p_revert;
		@(posedge aclk) disable iff (!aresetn)
		mode == DRC_AUTO && state == DRC_LOCK && cur_ok && revertive
		&& any_ok && best_rank < rank_arr[cur_ref]
		|=> cur_ref == $past(best_idx);
	endproperty
	a_revert: assert property (p_revert)
		else $error("revertive selection did not return to better input");

	property p_no_revert;
		@(posedge aclk) disable iff (!aresetn)
		mode == DRC_AUTO && state == DRC_LOCK && cur_ok && !revertive
		|=> $stable(cur_ref);
	endproperty
	a_no_revert: assert property (p_no_revert)
		else $error("non-revertive selection left a good input");

endmodule

`default_nettype wire

// ===== core/drc_regs.sv
// loop control and status registers behind an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "drc_map.svh"

module drc_regs import drc_pkg::*; (
	input  wire logic        aclk,              // system clock, 125 MHz
	input  wire logic        aresetn,           // synchronous reset, low
	input  wire logic [11:0] s_axi_awaddr,      // write address
	input  wire logic        s_axi_awvalid,     // write address valid
	output logic             s_axi_awready,     // write address ready
	input  wire logic [31:0] s_axi_wdata,       // write data
	input  wire logic [3:0]  s_axi_wstrb,       // write byte strobes
	input  wire logic        s_axi_wvalid,      // write data valid
	output logic             s_axi_wready,      // write data ready
	output logic      [1:0]  s_axi_bresp,       // write response
	output logic             s_axi_bvalid,      // write response valid
	input  wire logic        s_axi_bready,      // write response ready
	input  wire logic [11:0] s_axi_araddr,      // read address
	input  wire logic        s_axi_arvalid,     // read address valid
	output logic             s_axi_arready,     // read address ready
	output logic      [31:0] s_axi_rdata,       // read data
	output logic      [1:0]  s_axi_rresp,       // read response
	output logic             s_axi_rvalid,      // read data valid
	input  wire logic        s_axi_rready,      // read data ready
	input  wire logic [27:0] other_ranks,       // rank codes, inputs 0..6
	input  wire logic [1:0]  loop1_mode,        // first loop mode code
	input  wire logic [7:0]  ref_qualified,     // input monitor pins
	input  wire logic        phase_locked,      // loop lock detector pin
	output logic      [2:0]  loop1_ref_sel,     // selected input
	output logic      [7:0]  capture_ppm,       // capture range, ppm
	output logic             phase_buildout,    // absorb phase on switch
	output logic             phase_realign,     // realign on switch
	output logic      [7:0]  slope_limit_ms_s,  // slope bound, 0 = none
	output logic             loop2_enable,      // second loop running
	output logic             revertive,         // revertive switching
	output logic             freq_offset_apply, // free-run offset in use
	output logic             irq                // unmasked event pending
);

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic        aw_held, next_aw_held;
	logic        w_held, next_w_held;
	logic [11:0] awaddr_q, next_awaddr;
	logic [31:0] wdata_q, next_wdata;
	logic [3:0]  wstrb_q, next_wstrb;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic [7:0]  rank, next_rank;
	logic [7:0]  capture, next_capture;
	logic [7:0]  ctl_a, next_ctl_a;
	logic [7:0]  ctl_b, next_ctl_b;
	logic [7:0]  lock_bits, next_lock_bits;
	logic [2:0]  events, next_events;
	logic [2:0]  ev_mask, next_ev_mask;
	logic [7:0]  qual_s1, qual_s2;
	logic        lock_s1, lock_s2;
	logic        wr_fire;
	logic [7:0]  wr_idx;
	logic        wr_hit;
	logic        wr_lane0;
	logic [7:0]  rd_idx;
	logic [2:0]  ev_set;
	logic [2:0]  ev_clr;
	drc_sel_state_t sel_state;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// monitor and lock flags come from the loop's own timing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			qual_s1 <= 8'h00;
			qual_s2 <= 8'h00;
			lock_s1 <= 1'b0;
			lock_s2 <= 1'b0;
		end else begin
			qual_s1 <= ref_qualified;
			qual_s2 <= qual_s1;
			lock_s1 <= phase_locked;
			lock_s2 <= lock_s1;
		end
	end

	// ---------------------------------------------------------------
	// reference selection
	// ---------------------------------------------------------------
	drc_sel u_sel (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.mode       (loop1_mode),
		.ranks_flat ({rank[`DRC_RANK_HI:`DRC_RANK_LO], other_ranks}),
		.qualified  (qual_s2),
		.revertive  (ctl_b[`DRC_CTLB_REVERT]),
		.cur_ref    (loop1_ref_sel),
		.state      (sel_state)
	);

	// ---------------------------------------------------------------
	// write channel and control registers
	// ---------------------------------------------------------------
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx = awaddr_q[9:2];
	assign wr_lane0 = wr_fire && wr_hit && wstrb_q[0];
	assign wr_hit = awaddr_q[11:10] == 2'h0
	                && (wr_idx == `DRC_IDX_RANK || wr_idx == `DRC_IDX_LOCK
	                || wr_idx == `DRC_IDX_CAPTURE || wr_idx == `DRC_IDX_CTL_A
	                || wr_idx == `DRC_IDX_CTL_B || wr_idx == `DRC_IDX_EVENTS
	                || wr_idx == `DRC_IDX_EV_MASK);

	// address and data are taken in either order; the write acts once both sit
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_awaddr = awaddr_q;
		next_wdata = wdata_q;
		next_wstrb = wstrb_q;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rank = rank;
		next_capture = capture;
		next_ctl_a = ctl_a;
		next_ctl_b = ctl_b;
		next_ev_mask = ev_mask;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_wdata = s_axi_wdata;
			next_wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wr_hit ? `DRC_RESP_OKAY : `DRC_RESP_SLVERR;
		end
		// reserved bits of capture and both control registers keep their reset value; rank takes all eight bits
		if (wr_lane0) begin
			case (wr_idx)
			`DRC_IDX_RANK: next_rank = wdata_q[7:0];
			`DRC_IDX_CAPTURE: next_capture = `DRC_RST_CAPTURE
				& ~`DRC_WMASK_CAPTURE
				| wdata_q[7:0] & `DRC_WMASK_CAPTURE;
			`DRC_IDX_CTL_A: next_ctl_a = `DRC_RST_CTL_A & ~`DRC_WMASK_CTL_A
				| wdata_q[7:0] & `DRC_WMASK_CTL_A;
			`DRC_IDX_CTL_B: next_ctl_b = `DRC_RST_CTL_B & ~`DRC_WMASK_CTL_B
				| wdata_q[7:0] & `DRC_WMASK_CTL_B;
			`DRC_IDX_EV_MASK: next_ev_mask = wdata_q[2:0];
			default: next_rank = rank;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DRC_RESP_OKAY;
			rank <= `DRC_RST_RANK;
			capture <= `DRC_RST_CAPTURE;
			ctl_a <= `DRC_RST_CTL_A;
			ctl_b <= `DRC_RST_CTL_B;
			ev_mask <= 3'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			awaddr_q <= next_awaddr;
			wdata_q <= next_wdata;
			wstrb_q <= next_wstrb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			rank <= next_rank;
			capture <= next_capture;
			ctl_a <= next_ctl_a;
			ctl_b <= next_ctl_b;
			ev_mask <= next_ev_mask;
		end
	end

	// ---------------------------------------------------------------
	// lock state and sticky events
	// ---------------------------------------------------------------
	always_comb begin
		next_lock_bits = 8'h00;
		next_lock_bits[`DRC_LOCK_HOLD] = sel_state == DRC_HOLD;
		next_lock_bits[`DRC_LOCK_LOCKED] = lock_s2
			&& sel_state == DRC_LOCK;
		next_lock_bits[`DRC_LOCK_FAIL] = !qual_s2[loop1_ref_sel];
		// holdover entry, loss of lock, failure of the selected input
		ev_set = {next_lock_bits[2] & ~lock_bits[2],
		          lock_bits[1] & ~next_lock_bits[1],
		          next_lock_bits[0] & ~lock_bits[0]};
		ev_clr = (wr_lane0 && wr_idx == `DRC_IDX_EVENTS) ? wdata_q[2:0] : 3'h0;
		// a new event beats a clear landing in the same cycle
		next_events = events & ~ev_clr | ev_set;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_bits <= 8'h00;
			events <= 3'h0;
			irq <= 1'b0;
		end else begin
			lock_bits <= next_lock_bits;
			events <= next_events;
			irq <= |(next_events & ev_mask);
		end
	end

	// ---------------------------------------------------------------
	// read channel
	// ---------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx = s_axi_araddr[9:2];

	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = `DRC_RESP_OKAY;
			next_rdata = 32'h0000_0000;
			case (rd_idx)
			`DRC_IDX_RANK: next_rdata[7:0] = rank;
			`DRC_IDX_LOCK: next_rdata[7:0] = lock_bits;
			`DRC_IDX_CAPTURE: next_rdata[7:0] = capture;
			`DRC_IDX_CTL_A: next_rdata[7:0] = ctl_a;
			`DRC_IDX_CTL_B: next_rdata[7:0] = ctl_b;
			`DRC_IDX_EVENTS: next_rdata[2:0] = events;
			`DRC_IDX_EV_MASK: next_rdata[2:0] = ev_mask;
			default: next_rresp = `DRC_RESP_SLVERR;
			endcase
			if (s_axi_araddr[11:10] != 2'h0) begin
				next_rdata = 32'h0000_0000;
				next_rresp = `DRC_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `DRC_RESP_OKAY;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// ---------------------------------------------------------------
	// loop controls
	// ---------------------------------------------------------------
	// outputs follow the registers one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_ppm <= `DRC_PPM_CODE3;
			phase_buildout <= 1'b0;
			phase_realign <= 1'b0;
			slope_limit_ms_s <= `DRC_SLOPE_MS_S;
			loop2_enable <= 1'b0;
			revertive <= 1'b0;
			freq_offset_apply <= 1'b0;
		end else begin
			case (capture[1:0])
			2'h0: capture_ppm <= `DRC_PPM_CODE0;
			2'h1: capture_ppm <= `DRC_PPM_CODE1;
			2'h2: capture_ppm <= `DRC_PPM_CODE2;
			default: capture_ppm <= `DRC_PPM_CODE3;
			endcase
			phase_buildout <= ctl_a[`DRC_CTLA_ENABLE]
				&& !ctl_a[`DRC_CTLA_HITLESS];
			phase_realign <= ctl_a[`DRC_CTLA_ENABLE]
				&& ctl_a[`DRC_CTLA_HITLESS];
			slope_limit_ms_s <= ctl_a[`DRC_CTLA_SLOPE] ? 8'h00
				: `DRC_SLOPE_MS_S;
			loop2_enable <= ctl_a[`DRC_CTLA_ENABLE];
			revertive <= ctl_b[`DRC_CTLB_REVERT];
			freq_offset_apply <= ctl_b[`DRC_CTLB_OFFSET];
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_reg_write(logic [7:0] idx);
		wr_lane0 && wr_idx == idx;
	endsequence

	property p_rank_write;
		@(posedge aclk) disable iff (!aresetn)
		s_reg_write(`DRC_IDX_RANK)
		|=> rank[7:4] == $past(wdata_q[7:4]);
	endproperty
	a_rank_write: assert property (p_rank_write)
		else $error("rank field not updated by write");

	property p_hold_bit;
		@(posedge aclk) disable iff (!aresetn)
		$rose(sel_state == DRC_HOLD) |=> lock_bits[0] && events[0];
	endproperty
	a_hold_bit: assert property (p_hold_bit)
		else $error("holdover entry not shown in lock state");

	property p_lock_bit;
		@(posedge aclk) disable iff (!aresetn)
		lock_bits[1] |-> $past(lock_s2) && $past(sel_state) == DRC_LOCK;
	endproperty
	a_lock_bit: assert property (p_lock_bit)
		else $error("lock bit high without lock");

	property p_fail_bit;
		@(posedge aclk) disable iff (!aresetn)
		!qual_s2[loop1_ref_sel] |=> lock_bits[2];
	endproperty
	a_fail_bit: assert property (p_fail_bit)
		else $error("failed selected input not flagged");

	property p_capture;
		@(posedge aclk) disable iff (!aresetn)
		capture[1:0] == 2'h2 ##1 capture[1:0] == 2'h2
		|-> capture_ppm == `DRC_PPM_CODE2;
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture range code 10 not 130 ppm");

	property p_hitless;
		@(posedge aclk) disable iff (!aresetn)
		ctl_a[`DRC_CTLA_ENABLE]
		|=> phase_buildout == !$past(ctl_a[`DRC_CTLA_HITLESS])
		    && phase_realign == $past(ctl_a[`DRC_CTLA_HITLESS]);
	endproperty
	a_hitless: assert property (p_hitless)
		else $error("switch phase handling disagrees with hitless bit");

	property p_slope;
		@(posedge aclk) disable iff (!aresetn)
		!ctl_a[`DRC_CTLA_SLOPE] [*2] |-> slope_limit_ms_s == `DRC_SLOPE_MS_S;
	endproperty
	a_slope: assert property (p_slope)
		else $error("slope bound not 61 ms/s while bit clear");

	property p_enable_reset;
		@(posedge aclk) !$past(aresetn) |-> !loop2_enable && !revertive;
	endproperty
	a_enable_reset: assert property (p_enable_reset)
		else $error("second loop enabled or revertive after reset");

	property p_ctl_b;
		@(posedge aclk) disable iff (!aresetn)
		s_reg_write(`DRC_IDX_CTL_B) ##2 1'b1
		|-> freq_offset_apply == $past(wdata_q[1], 2)
		    && revertive == $past(wdata_q[0], 2);
	endproperty
	a_ctl_b: assert property (p_ctl_b)
		else $error("second control bits not applied two cycles on");

endmodule

`default_nettype wire

// ===== dv/tb_dpll_ref_control_status_regs.sv
// self-checking bench of the loop control and status registers
`timescale 1ns/1ps
`default_nettype none
`include "drc_map.svh"

module tb_dpll_ref_control_status_regs;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        aclk, aresetn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
	logic        lk, irq, buo, rea, l2e, rev, foa;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdt;
	logic [3:0]  ws;
	logic [1:0]  brs, rrs, mode;
	logic [27:0] oth;
	logic [7:0]  qual, ppm, slope;
	logic [2:0]  sel;
	int          error_cnt = 0;
	int          comparisons = 0;
	logic [7:0]  ppm_tab [4] = '{8'h0c, 8'h34, 8'h82, 8'h53};

	drc_regs u_drc_regs (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdt), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .other_ranks(oth), .loop1_mode(mode),
		.ref_qualified(qual), .phase_locked(lk), .loop1_ref_sel(sel),
		.capture_ppm(ppm), .phase_buildout(buo), .phase_realign(rea),
		.slope_limit_ms_s(slope), .loop2_enable(l2e), .revertive(rev),
		.freq_offset_apply(foa), .irq(irq));

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, s);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask

	// ready is sampled mid-cycle, where it is settled, and the channel is
	// released at the following rising edge, where the handshake happens
	task automatic wr(input logic [7:0] ix, d,
			input logic [1:0] er = `DRC_RESP_OKAY);
		logic a, w, b;
		logic [1:0] r;
		@(posedge aclk);
		awa <= {2'h0, ix, 2'h0};
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(negedge aclk);
			a = awr;
			w = wrd;
			b = bv;
			r = brs;
			@(posedge aclk);
			if (a) awv <= 1'b0;
			if (w) wv <= 1'b0;
		end while (!b);
		br <= 1'b0;
		chk("bresp", er, r);
	endtask

	task automatic rd(input logic [7:0] ix, e,
			input logic [1:0] er = `DRC_RESP_OKAY);
		logic a, v;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		ara <= {2'h0, ix, 2'h0};
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(negedge aclk);
			a = arr;
			v = rv;
			d = rdt;
			r = rrs;
			@(posedge aclk);
			if (a) arv <= 1'b0;
		end while (!v);
		rr <= 1'b0;
		chk("rdata", {24'h0, e}, d);
		chk("rresp", er, r);
	endtask

	task automatic ctla(input logic [7:0] w, rb, sl, input logic en, bo, ra);
		wr(`DRC_IDX_CTL_A, w);
		rd(`DRC_IDX_CTL_A, rb);
		chk("slope", sl, slope);
		chk("enable", en, l2e);
		chk("buildout", bo, buo);
		chk("realign", ra, rea);
	endtask

	// inputs pass a two-stage synchroniser, so allow margin before looking
	task automatic sett;
		repeat (8) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic results;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock, watchdog and test sequence
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		results;
	end

	initial begin
		aresetn = 1'b0;
		{awv, wv, br, arv, rr, awa, ara, wd} = '0;
		ws = 4'hf;
		oth = {7{4'h5}};
		mode = 2'h2;
		qual = 8'hff;
		lk = 1'b1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`DRC_IDX_RANK, 8'h76);
		rd(`DRC_IDX_CAPTURE, 8'h03);
		rd(`DRC_IDX_CTL_B, 8'h04);
		chk("ppm", 8'h53, ppm);
		ctla(8'h00, 8'h00, 8'h3d, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wr(`DRC_IDX_CAPTURE, 8'(i));
			sett;
			chk("ppm", ppm_tab[i], ppm);
		end
		wr(`DRC_IDX_CAPTURE, 8'hfe);
		rd(`DRC_IDX_CAPTURE, 8'h02);
		ctla(8'hff, 8'h91, 8'h00, 1'b1, 1'b0, 1'b1);
		ctla(8'h80, 8'h80, 8'h3d, 1'b1, 1'b1, 1'b0);
		wr(`DRC_IDX_CTL_B, 8'hff);
		rd(`DRC_IDX_CTL_B, 8'h07);
		chk("freq", 1'b1, foa);
		wr(`DRC_IDX_CTL_B, 8'h01);
		rd(`DRC_IDX_CTL_B, 8'h05);
		chk("freq", 1'b0, foa);
		chk("revert", 1'b1, rev);
		rd(8'h3f, 8'h00, `DRC_RESP_SLVERR);
		wr(8'h3f, 8'h12, `DRC_RESP_SLVERR);
		// input seven ranked best, then fail it and bring it back
		wr(`DRC_IDX_RANK, 8'h06);
		wr(`DRC_IDX_EV_MASK, 8'h01);
		mode <= 2'h3;
		sett;
		chk("sel", 3'h7, sel);
		rd(`DRC_IDX_LOCK, 8'h02);
		qual <= 8'h7f;
		sett;
		chk("sel", 3'h0, sel);
		@(posedge aclk);
		qual <= 8'hff;
		sett;
		chk("sel", 3'h7, sel);
		@(posedge aclk);
		qual <= 8'h00;
		sett;
		chk("irq", 1'b1, irq);
		rd(`DRC_IDX_LOCK, 8'h05);
		rd(`DRC_IDX_EVENTS, 8'h07);
		wr(`DRC_IDX_EVENTS, 8'h01);
		rd(`DRC_IDX_EVENTS, 8'h06);
		chk("irq", 1'b0, irq);
		// manual normal relocks on its own input; then lock pin, holdover
		qual <= 8'hff;
		mode <= 2'h0;
		sett;
		rd(`DRC_IDX_LOCK, 8'h02);
		lk <= 1'b0;
		sett;
		rd(`DRC_IDX_LOCK, 8'h00);
		mode <= 2'h1;
		sett;
		rd(`DRC_IDX_LOCK, 8'h01);
		rd(`DRC_IDX_EVENTS, 8'h07);
		chk("irq", 1'b1, irq);
		results;
	end
endmodule

`default_nettype wire
